// ==== pll_input_defs.svh ====
// Constants for the PLL input stage control block
// What this block does
// - Reference divides by one plus the three-bit divider code, 1 to 8.
// - With the internal fast RC source chosen, divider code is ignored, ratio 1.
// - Bit 7 set picks internal fast RC, cleared picks primary oscillator.
// - Band code 000 is bypass, 001-101 are bands, 110 and 111 reserved.
// - Divider, source and band fields load from configuration word two at reset.
// - Control register writes are accepted only after the unlock sequence.
// - All control writes are blocked while current oscillator selection is 001.
// - Bits 6 to 3 are unimplemented and always read zero.
`ifndef PLL_INPUT_DEFS_SVH
`define PLL_INPUT_DEFS_SVH
`define PLL_CONTROL_ADDR   6'h00
`define UNLOCK_ADDR        6'h04
`define STATUS_ADDR        6'h08
`define UNLOCK_KEY1        32'hAA99_6655
`define UNLOCK_KEY2        32'h5566_99AA
`define DIV_LSB            8
`define DIV_MSB            10
`define SRC_BIT            7
`define BAND_LSB           0
`define BAND_MSB           2
`define OSC_SEL_PLL        3'h1
`define BAND_BYPASS        3'h0
`define BAND_LAST_VALID    3'h5
`define DIV_ONE            3'h0
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2
`endif

// ==== pll_input_pkg.sv ====
// Types for the PLL input stage control block
package pll_input_pkg;
  typedef struct packed {
    logic [2:0] div_code;
    logic       src_frc;
    logic [2:0] band;
  } pll_cfg_t;
  typedef enum logic [1:0] {
    LOCKED  = 2'b00,
    HALFWAY = 2'b01,
    OPEN    = 2'b10
  } unlock_state_t;
endpackage

// ==== pll_input_config.sv ====
// PLL input stage control register with AXI4-Lite slave
`timescale 1ns/1ns
`include "pll_input_defs.svh"
module pll_input_config (
  // Clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // Configuration word two defaults
  input  wire pll_input_pkg::pll_cfg_t cfg_defaults,
  // Current oscillator selection
  input  wire logic [2:0]             current_osc_sel,
  // AXI4-Lite write address and data
  input  wire logic                   awvalid,
  output logic                        awready,
  input  wire logic [5:0]             awaddr,
  input  wire logic                   wvalid,
  output logic                        wready,
  input  wire logic [31:0]            wdata,
  input  wire logic [3:0]             wstrb,
  // AXI4-Lite write response
  output logic                        bvalid,
  input  wire logic                   bready,
  output logic [1:0]                  bresp,
  // AXI4-Lite read
  input  wire logic                   arvalid,
  output logic                        arready,
  input  wire logic [5:0]             araddr,
  output logic                        rvalid,
  input  wire logic                   rready,
  output logic [31:0]                 rdata,
  output logic [1:0]                  rresp,
  // PLL input stage controls
  output logic [2:0]                  input_divider_sel,
  output logic                        reference_source_sel,
  output logic [2:0]                  freq_band_sel,
  output logic [3:0]                  divide_ratio,
  output logic                        pll_bypass,
  output logic                        band_reserved
);
  pll_input_pkg::pll_cfg_t       cfg_q, cfg_d;
  pll_input_pkg::unlock_state_t  ulk_q, ulk_d;
  logic                          loaded_q;
  logic                          aw_held_q, w_held_q;
  logic [5:0]                    awaddr_q;
  logic [31:0]                   wdata_q;
  logic                          wstrb_q;
  logic                          bvalid_q, rvalid_q;
  logic [1:0]                    bresp_q, rresp_q;
  logic [31:0]                   rdata_q;

  // Word-aligned address match, shared by the write and read decoders
  function automatic logic addr_is(input logic [5:0] addr, input logic [5:0] target);
    logic [5:0] word_addr;
    word_addr = {addr[5:2], 2'b00};
    addr_is   = (word_addr == target);
  endfunction

  // Write channel capture and decode
  wire        aw_take   = awvalid && awready;
  wire        w_take    = wvalid && wready;
  // One write at a time: the next pair waits until the answer is taken
  wire        wr_go     = aw_held_q && w_held_q && !bvalid_q;
  wire        hit_ctl   = addr_is(awaddr_q, `PLL_CONTROL_ADDR);
  wire        hit_ulk   = addr_is(awaddr_q, `UNLOCK_ADDR);
  wire        hit_sts   = addr_is(awaddr_q, `STATUS_ADDR);
  wire        pll_active = (current_osc_sel == `OSC_SEL_PLL);
  wire        ctl_ok    = wr_go && hit_ctl && (ulk_q == pll_input_pkg::OPEN) && !pll_active;
  wire        ctl_bad   = wr_go && hit_ctl && !ctl_ok;
  wire        mapped_wr = hit_ctl || hit_ulk || hit_sts;
  // Error answer for unmapped or refused writes
  wire [1:0]  wr_resp   = (mapped_wr && !ctl_bad) ? `RESP_OKAY : `RESP_SLVERR;

  // Readies stay low until the defaults are in, so no request races the load
  assign awready = !aw_held_q && loaded_q;
  assign wready  = !w_held_q && loaded_q;
  assign arready = !rvalid_q && loaded_q;
  // Answer channels straight from their flops
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign rvalid  = rvalid_q;
  assign rdata   = rdata_q;
  assign rresp   = rresp_q;

  // Unlock sequence, key pair then one control write
  // Any control write relocks, accepted or not, so each one needs fresh keys
  always_comb begin
    ulk_d = ulk_q;
    if (wr_go && hit_ulk && wstrb_q) begin
      if (wdata_q == `UNLOCK_KEY1)
        ulk_d = pll_input_pkg::HALFWAY;
      else if (wdata_q == `UNLOCK_KEY2 && ulk_q == pll_input_pkg::HALFWAY)
        ulk_d = pll_input_pkg::OPEN;
      else
        ulk_d = pll_input_pkg::LOCKED;
    end else if (wr_go && hit_ctl) begin
      ulk_d = pll_input_pkg::LOCKED;
    end else begin
      case (ulk_q)
        pll_input_pkg::LOCKED:  ulk_d = pll_input_pkg::LOCKED;
        pll_input_pkg::HALFWAY: ulk_d = pll_input_pkg::HALFWAY;
        pll_input_pkg::OPEN:    ulk_d = pll_input_pkg::OPEN;
        default:                ulk_d = pll_input_pkg::LOCKED;
      endcase
    end
  end

  // Fields carried by an accepted control write
  wire [2:0]  wr_div    = wdata_q[`DIV_MSB:`DIV_LSB];
  wire        wr_src    = wdata_q[`SRC_BIT];
  wire [2:0]  wr_band   = wdata_q[`BAND_MSB:`BAND_LSB];
  // Strobes missing byte lane 0 or 1 leave the fields alone but still use up the unlock
  wire        ctl_load  = ctl_ok && wstrb_q;

  // Next control value
  always_comb begin
    cfg_d = cfg_q;
    if (!loaded_q) begin
      cfg_d = cfg_defaults;
    end else if (ctl_load) begin
      cfg_d.div_code = wr_div;
      cfg_d.src_frc  = wr_src;
      cfg_d.band     = wr_band;
    end
  end

  // Register state
  // Defaults load at the first edge after reset, then only writes move fields
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q    <= '0;
      loaded_q <= 1'b0;
      ulk_q    <= pll_input_pkg::LOCKED;
    end else begin
      cfg_q    <= cfg_d;
      loaded_q <= 1'b1;
      ulk_q    <= ulk_d;
    end
  end

  // Write address and data holding
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= 6'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 1'b0;
    end else begin
      if (aw_take) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= {awaddr[5:2], 2'b00};
      end else if (wr_go) begin
        aw_held_q <= 1'b0;
      end
      if (w_take) begin
        w_held_q <= 1'b1;
        wdata_q  <= wdata;
        wstrb_q  <= &wstrb[1:0];
      end else if (wr_go) begin
        w_held_q <= 1'b0;
      end
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_resp;
    end else if (bvalid_q && bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Read decode
  // bits 6 to 3 read zero
  wire [31:0] ctl_word = {21'h0, cfg_q.div_code, cfg_q.src_frc, 4'h0, cfg_q.band};
  // Status word: oscillator code, unlock open, PLL active
  wire        ulk_open = (ulk_q == pll_input_pkg::OPEN);
  wire [31:0] sts_word = {26'h0, pll_active, ulk_open, 1'b0, current_osc_sel};
  wire        rd_ctl  = addr_is(araddr, `PLL_CONTROL_ADDR);
  wire        rd_sts  = addr_is(araddr, `STATUS_ADDR);
  wire        rd_ulk  = addr_is(araddr, `UNLOCK_ADDR);
  // Read word and answer for the decoded address
  wire [31:0] rd_word = rd_ctl ? ctl_word : (rd_sts ? sts_word : 32'h0000_0000);
  wire [1:0]  rd_resp = (rd_ctl || rd_sts || rd_ulk) ? `RESP_OKAY : `RESP_SLVERR;

  // Read response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= `RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_word;
      rresp_q  <= rd_resp;
    end else if (rvalid_q && rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // Field outputs
  assign input_divider_sel    = cfg_q.div_code;
  assign reference_source_sel = cfg_q.src_frc;
  assign freq_band_sel        = cfg_q.band;
  wire [2:0] eff_div   = cfg_q.src_frc ? `DIV_ONE : cfg_q.div_code;
  wire [3:0] eff_div_w = {1'b0, eff_div};
  assign divide_ratio = eff_div_w + 4'h1;
  // band decode, reserved codes kept as written and only flagged
  assign pll_bypass    = (cfg_q.band == `BAND_BYPASS);
  assign band_reserved = (cfg_q.band > `BAND_LAST_VALID);
endmodule

// ==== pll_input_config_checker.sv ====
// Concurrent checks on the PLL input stage control ports
`timescale 1ns/1ns
module pll_input_config_checker (
  // Clock and reset
  input wire logic                    aclk,
  input wire logic                    aresetn,
  // Inputs seen
  input wire pll_input_pkg::pll_cfg_t cfg_defaults,
  input wire logic [2:0]              current_osc_sel,
  input wire logic                    wvalid,
  input wire logic                    wready,
  input wire logic [31:0]             wdata,
  // Outputs checked
  input wire logic                    bvalid,
  input wire logic [1:0]              bresp,
  input wire logic [2:0]              input_divider_sel,
  input wire logic                    reference_source_sel,
  input wire logic [2:0]              freq_band_sel,
  input wire logic [3:0]              divide_ratio,
  input wire logic                    pll_bypass,
  input wire logic                    band_reserved
);
  logic [31:0] wd_q;
  wire  [6:0]  fields = {input_divider_sel, reference_source_sel, freq_band_sel};
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Last write word taken
  always_ff @(posedge aclk) if (wvalid && wready) wd_q <= wdata;
  AST_DIV_RATIO: assert property (!reference_source_sel |-> divide_ratio == input_divider_sel + 4'h1)
    else $error("ratio wrong");
  AST_FRC_ONE: assert property (reference_source_sel |-> divide_ratio == 4'h1)
    else $error("fast RC ratio wrong");
  AST_BYPASS: assert property (pll_bypass == (freq_band_sel == 3'h0))
    else $error("bypass wrong");
  AST_RSVD: assert property (band_reserved == (freq_band_sel > 3'h5))
    else $error("reserved flag wrong");
  AST_RESET_LOAD: assert property (disable iff (1'b0) $rose(aresetn) |=> fields == $past(cfg_defaults))
    else $error("defaults not loaded");
  AST_PLL_BLOCK: assert property ((current_osc_sel == 3'h1) [*3] |-> $stable(fields))
    else $error("write while PLL active");
  AST_WR_ONLY: assert property (!$stable(fields) && $past(aresetn, 2) |-> $rose(bvalid) && bresp == 2'h0)
    else $error("fields moved without write");
  AST_WR_VALUE: assert property (!$stable(fields) && $past(aresetn, 2) |-> fields == {wd_q[10:7], wd_q[2:0]})
    else $error("fields differ from write");
  COV_BLOCKED: cover property ($rose(bvalid) && bresp == 2'h2);
  COV_FRC: cover property (reference_source_sel && input_divider_sel != 3'h0);
  COV_RSVD: cover property (band_reserved);
endmodule
bind pll_input_config pll_input_config_checker chk (.*);

// ==== testbench.sv ====
// Bench for the PLL input stage control block
`timescale 1ns/1ns
`include "pll_input_defs.svh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; \
  $display("CHECK FAILED %0t %h %h", $time, a, b); end end
module testbench;
  logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, arvalid = 0, ta, tw, tr;
  logic        bready = 1, rready = 1, awready, wready, arready, bvalid, rvalid;
  logic        reference_source_sel, pll_bypass, band_reserved;
  logic [1:0]  bresp, rresp, resp;
  logic [2:0]  current_osc_sel = 0, input_divider_sel, freq_band_sel;
  logic [3:0]  wstrb = 4'hF, divide_ratio;
  logic [5:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, rd;
  int          n_errors = 0, checks_done = 0;
  pll_input_pkg::pll_cfg_t cfg_defaults = 7'h53;
  pll_input_config DUT (.*);
  always #4 aclk = ~aclk;
  // One write, address and data offered together
  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    do begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tr = bvalid;
      resp = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 0;
      if (tw) wvalid <= 0;
    end while (!tr);
    `CHK(resp, er)
  endtask
  // One read and its answer
  task automatic rdc(input logic [5:0] a, input logic [31:0] ed, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1;
    do begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid;
      resp = rresp;
      rd = rdata;
      @(posedge aclk);
      if (ta) arvalid <= 0;
    end while (!tr);
    `CHK(rd, ed)
    `CHK(resp, er)
  endtask
  task unl;
    wr(`UNLOCK_ADDR, `UNLOCK_KEY1, `RESP_OKAY);
    wr(`UNLOCK_ADDR, `UNLOCK_KEY2, `RESP_OKAY);
  endtask
  // Defaults, a write without unlock, then a broken key pair
  task t_locked;
    rdc(`PLL_CONTROL_ADDR, 32'h0000_0503, `RESP_OKAY);
    wr(`PLL_CONTROL_ADDR, 32'h0000_0001, `RESP_SLVERR);
    wr(`UNLOCK_ADDR, `UNLOCK_KEY1, `RESP_OKAY);
    wr(`UNLOCK_ADDR, 32'h0000_0000, `RESP_OKAY);
    wr(`PLL_CONTROL_ADDR, 32'h0000_0001, `RESP_SLVERR);
    rdc(`UNLOCK_ADDR, 32'h0000_0000, `RESP_OKAY);
    rdc(`PLL_CONTROL_ADDR, 32'h0000_0503, `RESP_OKAY);
  endtask
  // Fast RC source with loose bits written
  task t_frc;
    unl;
    wr(`PLL_CONTROL_ADDR, 32'h0000_07FD, `RESP_OKAY);
    rdc(`PLL_CONTROL_ADDR, 32'h0000_0785, `RESP_OKAY);
    `CHK(reference_source_sel, 1'h1)
    `CHK(divide_ratio, 4'h1)
    unl;
    wstrb <= 4'hC;
    wr(`PLL_CONTROL_ADDR, 32'h0000_0000, `RESP_OKAY);
    wstrb <= 4'hF;
    wr(`PLL_CONTROL_ADDR, 32'h0000_0000, `RESP_SLVERR);
    rdc(`PLL_CONTROL_ADDR, 32'h0000_0785, `RESP_OKAY);
  endtask
  // Every divider and band code
  task t_codes;
    for (int i = 0; i < 8; i++) begin
      unl;
      wr(`PLL_CONTROL_ADDR, {21'h0, 3'(i), 5'h0, 3'(i)}, `RESP_OKAY);
      `CHK(divide_ratio, 4'(i + 1))
      `CHK({pll_bypass, band_reserved}, {i == 0, i > 5})
      `CHK({input_divider_sel, freq_band_sel}, {3'(i), 3'(i)})
    end
  endtask
  // Write while the PLL drives the system, then an unmapped read
  task t_active;
    current_osc_sel <= `OSC_SEL_PLL;
    unl;
    rdc(`STATUS_ADDR, 32'h0000_0031, `RESP_OKAY);
    wr(`PLL_CONTROL_ADDR, 32'h0000_0000, `RESP_SLVERR);
    rdc(`STATUS_ADDR, 32'h0000_0021, `RESP_OKAY);
    rdc(`PLL_CONTROL_ADDR, 32'h0000_0707, `RESP_OKAY);
    rdc(6'h0C, 32'h0000_0000, `RESP_SLVERR);
    current_osc_sel <= 3'h0;
  endtask
  task close_out;
    if (n_errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    repeat (2) @(posedge aclk);
    t_locked;
    t_frc;
    t_codes;
    t_active;
    close_out;
  end
  // Hang guard
  initial begin
    #200000;
    n_errors++;
    close_out;
  end
endmodule
